// ---- rtl/pfds_top.sv ----
`timescale 1ns/1ps
module pfds_top
	import pfds_pkg::*;
#(
	parameter bit LARGE_VARIANT = 1'b1
)
(
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [PFDS_ADR_W-1:0] i_wb_adr,
	input wire logic [3:0] i_wb_sel,
	input wire logic [PFDS_DAT_W-1:0] i_wb_dat,
	output logic [PFDS_DAT_W-1:0] o_wb_dat,
	output logic o_wb_ack,
	input wire logic [7:0] i_pa_pin,
	input wire logic [7:0] i_pa_gpio_out,
	input wire pfds_periph_tx_t i_periph_tx,
	input wire pfds_periph_rx_t i_alt_rx,
	output logic [7:0] o_pa_out,
	output logic [7:0] o_pa_oe,
	output logic [3:0] o_pa_lcd_sel,
	output pfds_periph_rx_t o_periph_rx,
	output pfds_drive_t o_pa_drive,
	output pfds_drive_t o_pb_drive,
	output pfds_drive_t o_pc_drive,
	output pfds_drive_t o_pd_drive,
	output logic [7:0] o_pb_dir,
	output logic [7:0] o_pc_dir,
	output logic [7:0] o_pd_dir,
	output logic [7:0] o_port_a_function_select_high,
	output logic [7:0] o_port_b_function_select_low,
	output logic [7:0] o_port_b_function_select_high,
	output logic [7:0] o_port_c_function_select_low,
	output logic [7:0] o_port_c_function_select_high,
	output logic [7:0] o_port_d_function_select,
	output logic [7:0] o_ifs
);
	typedef enum {PFDS_WB_IDLE, PFDS_WB_ACK} pfds_wb_state_t;

	// Variant masks fixed at elaboration
	localparam logic [7:0] MSK_DLS1 = LARGE_VARIANT ? PFDS_MSK_LOW6 : PFDS_MSK_LOW2;
	localparam logic [7:0] MSK_PORT_C_FUNCTION_SELECT_LOW = LARGE_VARIANT ? PFDS_MSK_FULL : PFDS_MSK_LOW6;
	localparam logic [7:0] MSK_PORT_C_FUNCTION_SELECT_HIGH = LARGE_VARIANT ? PFDS_MSK_LOW6 : PFDS_MSK_NONE;
	localparam logic [7:0] MSK_PORT_D_FUNCTION_SELECT = LARGE_VARIANT ? PFDS_MSK_FULL : PFDS_MSK_NONE;
	localparam logic [7:0] MSK_IFS = LARGE_VARIANT ? PFDS_MSK_IFS_L : PFDS_MSK_IFS_S;
	localparam logic [7:0] MSK_PC_DIR = LARGE_VARIANT ? PFDS_MSK_PC_DIR_L : PFDS_MSK_PC_DIR_S;
	localparam logic [7:0] MSK_PD_DIR = LARGE_VARIANT ? PFDS_MSK_PD_DIR_L : PFDS_MSK_NONE;

	pfds_regs_t regs_q;
	pfds_regs_t regs_d;
	pfds_wb_state_t wb_state_q;
	pfds_wb_state_t wb_state_d;
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;
	logic [7:0] pa_meta_q;
	logic [7:0] pa_sync_q;
	logic wb_req;
	logic wb_commit;
	logic [7:0] wr_byte;
	logic [7:0] rd_byte;
	pfds_pins_t pa_low;
	pfds_level_t pa_lvl;
	pfds_level_t pb_lvl;
	pfds_level_t pc_lvl;
	pfds_level_t pd_lvl;
	logic [7:0] pa_push_pull;

	assign wb_req = i_wb_cyc & i_wb_stb;
	// Write lands on the edge where the master sees ack
	assign wb_commit = wb_req & i_wb_we & (wb_state_q == PFDS_WB_ACK) & i_wb_sel[0];
	assign wr_byte = i_wb_dat[7:0];

	// Bus handshake: one wait cycle, ack for exactly one cycle
	always_comb
	begin
		wb_state_d = wb_state_q;
		case (wb_state_q)
			PFDS_WB_IDLE:
			begin
				if (wb_req)
				begin
					wb_state_d = PFDS_WB_ACK;
				end
			end
			PFDS_WB_ACK:
			begin
				wb_state_d = PFDS_WB_IDLE;
			end
			default:
			begin
				wb_state_d = PFDS_WB_IDLE;
			end
		endcase
	end

	// Read mux; unmapped offsets read zero
	always_comb
	begin
		rd_byte = 8'h00;
		case (i_wb_adr)
			PFDS_OFF_DLS0: rd_byte = regs_q.dls0;
			PFDS_OFF_DLS1: rd_byte = regs_q.dls1 & MSK_DLS1;
			PFDS_OFF_PORT_A_FUNCTION_SELECT_LOW: rd_byte = regs_q.port_a_function_select_low;
			PFDS_OFF_PORT_A_FUNCTION_SELECT_HIGH: rd_byte = regs_q.port_a_function_select_high;
			PFDS_OFF_PORT_B_FUNCTION_SELECT_LOW: rd_byte = regs_q.port_b_function_select_low;
			PFDS_OFF_PORT_B_FUNCTION_SELECT_HIGH: rd_byte = regs_q.port_b_function_select_high & PFDS_MSK_LOW6;
			PFDS_OFF_PORT_C_FUNCTION_SELECT_LOW: rd_byte = regs_q.port_c_function_select_low & MSK_PORT_C_FUNCTION_SELECT_LOW;
			PFDS_OFF_PORT_C_FUNCTION_SELECT_HIGH: rd_byte = regs_q.port_c_function_select_high & MSK_PORT_C_FUNCTION_SELECT_HIGH;
			PFDS_OFF_PORT_D_FUNCTION_SELECT: rd_byte = regs_q.port_d_function_select & MSK_PORT_D_FUNCTION_SELECT;
			PFDS_OFF_IFS: rd_byte = regs_q.input_source_select & MSK_IFS;
			PFDS_OFF_PA_DIR: rd_byte = regs_q.pa_dir;
			PFDS_OFF_PB_DIR: rd_byte = regs_q.pb_dir & PFDS_MSK_PB_DIR;
			PFDS_OFF_PC_DIR: rd_byte = regs_q.pc_dir & MSK_PC_DIR;
			PFDS_OFF_PD_DIR: rd_byte = regs_q.pd_dir & MSK_PD_DIR;
			PFDS_OFF_PA_PINS: rd_byte = pa_sync_q;
			default: rd_byte = 8'h00;
		endcase
		rdata_d = rdata_q;
		if (wb_req && (wb_state_q == PFDS_WB_IDLE))
		begin
			rdata_d = rd_byte;
		end
	end

	// Register writes, masked so unimplemented bits stay zero
	always_comb
	begin
		regs_d = regs_q;
		if (wb_commit)
		begin
			case (i_wb_adr)
				PFDS_OFF_DLS0: regs_d.dls0 = wr_byte;
				PFDS_OFF_DLS1: regs_d.dls1 = wr_byte & MSK_DLS1;
				PFDS_OFF_PORT_A_FUNCTION_SELECT_LOW: regs_d.port_a_function_select_low = wr_byte;
				PFDS_OFF_PORT_A_FUNCTION_SELECT_HIGH: regs_d.port_a_function_select_high = wr_byte;
				PFDS_OFF_PORT_B_FUNCTION_SELECT_LOW: regs_d.port_b_function_select_low = wr_byte;
				PFDS_OFF_PORT_B_FUNCTION_SELECT_HIGH: regs_d.port_b_function_select_high = wr_byte & PFDS_MSK_LOW6;
				PFDS_OFF_PORT_C_FUNCTION_SELECT_LOW: regs_d.port_c_function_select_low = wr_byte & MSK_PORT_C_FUNCTION_SELECT_LOW;
				PFDS_OFF_PORT_C_FUNCTION_SELECT_HIGH: regs_d.port_c_function_select_high = wr_byte & MSK_PORT_C_FUNCTION_SELECT_HIGH;
				PFDS_OFF_PORT_D_FUNCTION_SELECT: regs_d.port_d_function_select = wr_byte & MSK_PORT_D_FUNCTION_SELECT;
				PFDS_OFF_IFS: regs_d.input_source_select = wr_byte & MSK_IFS;
				PFDS_OFF_PA_DIR: regs_d.pa_dir = wr_byte;
				PFDS_OFF_PB_DIR: regs_d.pb_dir = wr_byte & PFDS_MSK_PB_DIR;
				PFDS_OFF_PC_DIR: regs_d.pc_dir = wr_byte & MSK_PC_DIR;
				PFDS_OFF_PD_DIR: regs_d.pd_dir = wr_byte & MSK_PD_DIR;
				default: regs_d = regs_q;
			endcase
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			wb_state_q <= PFDS_WB_IDLE;
			rdata_q <= 8'h00;
			pa_meta_q <= 8'h00;
			pa_sync_q <= 8'h00;
			regs_q.dls0 <= PFDS_RST_SEL;
			regs_q.dls1 <= PFDS_RST_SEL;
			regs_q.port_a_function_select_low <= PFDS_RST_SEL;
			regs_q.port_a_function_select_high <= PFDS_RST_SEL;
			regs_q.port_b_function_select_low <= PFDS_RST_SEL;
			regs_q.port_b_function_select_high <= PFDS_RST_SEL;
			regs_q.port_c_function_select_low <= PFDS_RST_SEL;
			regs_q.port_c_function_select_high <= PFDS_RST_SEL;
			regs_q.port_d_function_select <= PFDS_RST_SEL;
			regs_q.input_source_select <= PFDS_RST_SEL;
			regs_q.pa_dir <= PFDS_RST_DIR;
			regs_q.pb_dir <= PFDS_RST_DIR & PFDS_MSK_PB_DIR;
			regs_q.pc_dir <= PFDS_RST_DIR & MSK_PC_DIR;
			regs_q.pd_dir <= PFDS_RST_DIR & MSK_PD_DIR;
		end
		else
		begin
			wb_state_q <= wb_state_d;
			rdata_q <= rdata_d;
			// Pins are asynchronous; two stages before any logic looks
			pa_meta_q <= i_pa_pin;
			pa_sync_q <= pa_meta_q;
			regs_q <= regs_d;
		end
	end

	assign o_wb_ack = (wb_state_q == PFDS_WB_ACK) & wb_req;
	assign o_wb_dat = {24'h000000, rdata_q};

	// Port A low pins are the only ones with a decoded function mux
	pfds_pa_mux u_pa_mux (
		.i_sel(regs_q.port_a_function_select_low),
		.i_ifs(regs_q.input_source_select),
		.i_dir(regs_q.pa_dir[3:0]),
		.i_gpio_out(i_pa_gpio_out[3:0]),
		.i_pin_in(pa_sync_q[3:0]),
		.i_tx(i_periph_tx),
		.i_alt_rx(i_alt_rx),
		.o_pins(pa_low),
		.o_rx(o_periph_rx)
	);

	assign o_pa_out = {i_pa_gpio_out[7:4], pa_low.out};
	assign o_pa_oe = {~regs_q.pa_dir[7:4], pa_low.oe};
	assign o_pa_lcd_sel = pa_low.lcd_sel;
	assign pa_push_pull = {~regs_q.pa_dir[7:4], pa_low.push_pull};

	// Drive level per pin from its group field
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++)
		begin : g_drive
			if (gi < 4)
			begin : g_low
				assign pa_lvl[gi] = regs_q.dls0[PFDS_DLS0_PA_LO +: 2];
				assign pb_lvl[gi] = regs_q.dls0[PFDS_DLS0_PB_LO +: 2];
				assign pd_lvl[gi] = regs_q.dls1[PFDS_DLS1_PD +: 2];
				if (LARGE_VARIANT || gi < 3)
				begin : g_pc
					assign pc_lvl[gi] = regs_q.dls1[PFDS_DLS1_PC_LO +: 2];
				end
				else
				begin : g_pc_none
					assign pc_lvl[gi] = PFDS_LVL_MIN;
				end
			end
			else
			begin : g_high
				assign pa_lvl[gi] = regs_q.dls0[PFDS_DLS0_PA_HI +: 2];
				assign pb_lvl[gi] = regs_q.dls0[PFDS_DLS0_PB_HI +: 2];
				assign pc_lvl[gi] = regs_q.dls1[PFDS_DLS1_PC_HI +: 2];
				assign pd_lvl[gi] = PFDS_LVL_MIN;
			end
			// Level is forced to minimum when the pin is not push-pull
			assign o_pa_drive.en[gi] = pa_push_pull[gi];
			assign o_pa_drive.level[gi] = pa_push_pull[gi] ? pa_lvl[gi] : PFDS_LVL_MIN;
			assign o_pb_drive.en[gi] = ~regs_q.pb_dir[gi] & PFDS_MSK_PB_DIR[gi];
			assign o_pb_drive.level[gi] = o_pb_drive.en[gi] ? pb_lvl[gi] : PFDS_LVL_MIN;
			assign o_pc_drive.en[gi] = ~regs_q.pc_dir[gi] & MSK_PC_DIR[gi];
			assign o_pc_drive.level[gi] = o_pc_drive.en[gi] ? pc_lvl[gi] : PFDS_LVL_MIN;
			assign o_pd_drive.en[gi] = ~regs_q.pd_dir[gi] & MSK_PD_DIR[gi];
			assign o_pd_drive.level[gi] = o_pd_drive.en[gi] ? pd_lvl[gi] : PFDS_LVL_MIN;
		end
	endgenerate

	// Remaining selects go to pin logic outside this block
	assign o_pb_dir = regs_q.pb_dir;
	assign o_pc_dir = regs_q.pc_dir;
	assign o_pd_dir = regs_q.pd_dir;
	assign o_port_a_function_select_high = regs_q.port_a_function_select_high;
	assign o_port_b_function_select_low = regs_q.port_b_function_select_low;
	assign o_port_b_function_select_high = regs_q.port_b_function_select_high;
	assign o_port_c_function_select_low = regs_q.port_c_function_select_low;
	assign o_port_c_function_select_high = regs_q.port_c_function_select_high;
	assign o_port_d_function_select = regs_q.port_d_function_select;
	assign o_ifs = regs_q.input_source_select;

endmodule : pfds_top

// ---- rtl/pfds_pkg.sv ----
package pfds_pkg;

	localparam int PFDS_ADR_W = 8;
	localparam int PFDS_DAT_W = 32;

	localparam logic [7:0] PFDS_OFF_DLS0 = 8'h00;
	localparam logic [7:0] PFDS_OFF_DLS1 = 8'h04;
	localparam logic [7:0] PFDS_OFF_PORT_A_FUNCTION_SELECT_LOW = 8'h08;
	localparam logic [7:0] PFDS_OFF_PORT_A_FUNCTION_SELECT_HIGH = 8'h0C;
	localparam logic [7:0] PFDS_OFF_PORT_B_FUNCTION_SELECT_LOW = 8'h10;
	localparam logic [7:0] PFDS_OFF_PORT_B_FUNCTION_SELECT_HIGH = 8'h14;
	localparam logic [7:0] PFDS_OFF_PORT_C_FUNCTION_SELECT_LOW = 8'h18;
	localparam logic [7:0] PFDS_OFF_PORT_C_FUNCTION_SELECT_HIGH = 8'h1C;
	localparam logic [7:0] PFDS_OFF_PORT_D_FUNCTION_SELECT = 8'h20;
	localparam logic [7:0] PFDS_OFF_IFS = 8'h24;
	localparam logic [7:0] PFDS_OFF_PA_DIR = 8'h28;
	localparam logic [7:0] PFDS_OFF_PB_DIR = 8'h2C;
	localparam logic [7:0] PFDS_OFF_PC_DIR = 8'h30;
	localparam logic [7:0] PFDS_OFF_PD_DIR = 8'h34;
	localparam logic [7:0] PFDS_OFF_PA_PINS = 8'h38;

	localparam logic [7:0] PFDS_RST_SEL = 8'h00;
	localparam logic [7:0] PFDS_RST_DIR = 8'hFF;

	// Implemented-bit masks, larger and smaller variant
	localparam logic [7:0] PFDS_MSK_FULL = 8'hFF;
	localparam logic [7:0] PFDS_MSK_LOW6 = 8'h3F;
	localparam logic [7:0] PFDS_MSK_LOW2 = 8'h03;
	localparam logic [7:0] PFDS_MSK_NONE = 8'h00;
	localparam logic [7:0] PFDS_MSK_IFS_L = 8'h3F;
	localparam logic [7:0] PFDS_MSK_IFS_S = 8'h30;
	localparam logic [7:0] PFDS_MSK_PB_DIR = 8'h7F;
	localparam logic [7:0] PFDS_MSK_PC_DIR_L = 8'h7F;
	localparam logic [7:0] PFDS_MSK_PC_DIR_S = 8'h07;
	localparam logic [7:0] PFDS_MSK_PD_DIR_L = 8'h0F;

	// Field positions, drive-select registers
	localparam int PFDS_DLS0_PA_LO = 0;
	localparam int PFDS_DLS0_PA_HI = 2;
	localparam int PFDS_DLS0_PB_LO = 4;
	localparam int PFDS_DLS0_PB_HI = 6;
	localparam int PFDS_DLS1_PC_LO = 0;
	localparam int PFDS_DLS1_PC_HI = 2;
	localparam int PFDS_DLS1_PD = 4;

	// Field positions, port A low select register
	localparam int PFDS_PORT_A_FUNCTION_SELECT_LOW_PIN0 = 0;
	localparam int PFDS_PORT_A_FUNCTION_SELECT_LOW_PIN1 = 2;
	localparam int PFDS_PORT_A_FUNCTION_SELECT_LOW_PIN2 = 4;
	localparam int PFDS_PORT_A_FUNCTION_SELECT_LOW_PIN3 = 6;

	// Bit positions, input source select register
	localparam int PFDS_IFS_RX = 0;
	localparam int PFDS_IFS_CS = 1;
	localparam int PFDS_IFS_SCK = 2;
	localparam int PFDS_IFS_SDI = 3;
	localparam int PFDS_IFS_IRQ0 = 4;
	localparam int PFDS_IFS_IRQ1 = 5;

	// Drive level codes
	localparam logic [1:0] PFDS_LVL_MIN = 2'h0;
	localparam logic [1:0] PFDS_LVL_MAX = 2'h3;

	// Port A low select codes
	localparam logic [1:0] PFDS_FN_GPIO = 2'h0;
	localparam logic [1:0] PFDS_FN_ALT1 = 2'h1;
	localparam logic [1:0] PFDS_FN_ALT2 = 2'h2;
	localparam logic [1:0] PFDS_FN_LCD = 2'h3;

	typedef logic [7:0][1:0] pfds_level_t;

	typedef struct packed {
		logic [7:0] en;
		pfds_level_t level;
	} pfds_drive_t;

	typedef struct packed {
		logic [7:0] dls0;
		logic [7:0] dls1;
		logic [7:0] port_a_function_select_low;
		logic [7:0] port_a_function_select_high;
		logic [7:0] port_b_function_select_low;
		logic [7:0] port_b_function_select_high;
		logic [7:0] port_c_function_select_low;
		logic [7:0] port_c_function_select_high;
		logic [7:0] port_d_function_select;
		logic [7:0] input_source_select;
		logic [7:0] pa_dir;
		logic [7:0] pb_dir;
		logic [7:0] pc_dir;
		logic [7:0] pd_dir;
	} pfds_regs_t;

	typedef struct packed {
		logic sdo;
		logic cmp_out;
		logic standard_timer_output;
		logic sda_low;
	} pfds_periph_tx_t;

	typedef struct packed {
		logic irq1;
		logic irq0;
		logic serial_in;
	} pfds_periph_rx_t;

	typedef struct packed {
		logic [3:0] out;
		logic [3:0] oe;
		logic [3:0] push_pull;
		logic [3:0] lcd_sel;
	} pfds_pins_t;

endpackage : pfds_pkg

// ---- rtl/pfds_pa_mux.sv ----
`timescale 1ns/1ps
module pfds_pa_mux
	import pfds_pkg::*;
(
	input wire logic [7:0] i_sel,
	input wire logic [7:0] i_ifs,
	input wire logic [3:0] i_dir,
	input wire logic [3:0] i_gpio_out,
	input wire logic [3:0] i_pin_in,
	input wire pfds_periph_tx_t i_tx,
	input wire pfds_periph_rx_t i_alt_rx,
	output pfds_pins_t o_pins,
	output pfds_periph_rx_t o_rx
);
	logic [1:0] fn0;
	logic [1:0] fn1;
	logic [1:0] fn2;
	logic [1:0] fn3;
	logic [3:0] gpio;

	assign fn0 = i_sel[PFDS_PORT_A_FUNCTION_SELECT_LOW_PIN0 +: 2];
	assign fn1 = i_sel[PFDS_PORT_A_FUNCTION_SELECT_LOW_PIN1 +: 2];
	assign fn2 = i_sel[PFDS_PORT_A_FUNCTION_SELECT_LOW_PIN2 +: 2];
	assign fn3 = i_sel[PFDS_PORT_A_FUNCTION_SELECT_LOW_PIN3 +: 2];

	always_comb
	begin
		gpio = {fn3 == PFDS_FN_GPIO, fn2 != PFDS_FN_LCD, fn1 <= PFDS_FN_ALT1, fn0 <= PFDS_FN_ALT1};
		o_pins.lcd_sel = {fn3 == PFDS_FN_LCD, fn2 == PFDS_FN_LCD, fn1 == PFDS_FN_LCD,
			fn0 == PFDS_FN_LCD};
		o_pins.out = i_gpio_out & gpio;
		o_pins.oe = ~i_dir & gpio;
		// Pin 0
		if (fn0 == PFDS_FN_ALT2)
		begin
			o_pins.out[0] = i_tx.standard_timer_output;
			o_pins.oe[0] = 1'b1;
		end
		// Pin 1
		if (fn1 == PFDS_FN_ALT2)
		begin
			o_pins.out[1] = i_tx.sdo;
			o_pins.oe[1] = 1'b1;
		end
		// Pin 3: serial data is open drain, so it never counts as push-pull
		if (fn3 == PFDS_FN_ALT1)
		begin
			o_pins.out[3] = 1'b0;
			o_pins.oe[3] = i_tx.sda_low;
		end
		else if (fn3 == PFDS_FN_ALT2)
		begin
			o_pins.out[3] = i_tx.cmp_out;
			o_pins.oe[3] = 1'b1;
		end
		o_pins.push_pull = (~i_dir & gpio) | {fn3 == PFDS_FN_ALT2, 1'b0, fn1 == PFDS_FN_ALT2,
			fn0 == PFDS_FN_ALT2};
		// Interrupt inputs share the GPIO codes and read the pin only as input
		o_rx.irq1 = i_ifs[PFDS_IFS_IRQ1] ? i_alt_rx.irq1 : (gpio[2] & i_dir[2] & i_pin_in[2]);
		o_rx.irq0 = i_ifs[PFDS_IFS_IRQ0] ? i_alt_rx.irq0 : (gpio[1] & i_dir[1] & i_pin_in[1]);
		o_rx.serial_in = i_ifs[PFDS_IFS_SDI] ? i_alt_rx.serial_in :
			((fn3 == PFDS_FN_ALT1) & i_pin_in[3]);
	end

endmodule : pfds_pa_mux

// ---- testbench/pfds_checker.sv ----
`timescale 1ns/1ps
module pfds_checker
	import pfds_pkg::*;
#(
	parameter bit LARGE_VARIANT = 1'b1
)
(
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [PFDS_DAT_W-1:0] o_wb_dat,
	input wire logic o_wb_ack,
	input wire pfds_drive_t o_pa_drive,
	input wire pfds_drive_t o_pb_drive,
	input wire logic [7:0] o_pb_dir,
	input wire logic [7:0] o_port_b_function_select_low,
	input wire logic [7:0] o_port_b_function_select_high,
	input wire logic [7:0] o_port_c_function_select_high,
	input wire logic [7:0] o_ifs
);
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_reset_n);
	sequence req_s;
		$rose(i_wb_cyc && i_wb_stb);
	endsequence
	sequence ack_s;
		o_wb_ack ##1 !o_wb_ack;
	endsequence
	ack_timing_a: assert property (req_s |=> ack_s)
		else $error("ack not a single pulse one cycle after request");
	read_upper_a: assert property (o_wb_ack |-> o_wb_dat[31:8] == 24'h000000)
		else $error("read data upper bits not zero");
	pb_enable_a: assert property (o_pb_drive.en[6:0] == ~o_pb_dir[6:0])
		else $error("port B drive enable does not follow direction");
	pb_level_gate_a: assert property (!o_pb_drive.en[0] |-> o_pb_drive.level[0] == 2'h0)
		else $error("drive level shown on a pin that is not an output");
	pa_group_a: assert property ((o_pa_drive.en[4] && o_pa_drive.en[7])
		|-> o_pa_drive.level[4] == o_pa_drive.level[7])
		else $error("port A upper group levels differ");
	pb_group_a: assert property ((o_pb_drive.en[0] && o_pb_drive.en[3])
		|-> o_pb_drive.level[0] == o_pb_drive.level[3])
		else $error("port B lower group levels differ");
	sel_reserved_a: assert property (o_port_b_function_select_high[7:6] == 2'h0 && o_port_c_function_select_high[7:6] == 2'h0)
		else $error("unimplemented select bits set");
	ifs_reserved_a: assert property (o_ifs[7:6] == 2'h0
		&& (LARGE_VARIANT || o_ifs[3:0] == 4'h0))
		else $error("unimplemented input source bits set");
	write_timing_a: assert property ($changed(o_port_b_function_select_low) |-> $past(o_wb_ack && i_wb_we))
		else $error("select register changed without a write");
endmodule : pfds_checker

bind pfds_top pfds_checker #(.LARGE_VARIANT(LARGE_VARIANT)) u_chk (.i_clk(i_clk),
	.i_reset_n(i_reset_n), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we),
	.o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .o_pa_drive(o_pa_drive),
	.o_pb_drive(o_pb_drive), .o_pb_dir(o_pb_dir), .o_port_b_function_select_low(o_port_b_function_select_low), .o_port_b_function_select_high(o_port_b_function_select_high),
	.o_port_c_function_select_high(o_port_c_function_select_high), .o_ifs(o_ifs));

// ---- testbench/tb_pin_function_and_drive_select.sv ----
`timescale 1ns/1ps
module tb_pin_function_and_drive_select;
	import pfds_pkg::*;
	logic i_clk, i_reset_n, cyc, stb, we, ack;
	logic [7:0] adr, pa_pin, gpio, pa_out, pa_oe, pb_dir, rd;
	logic [7:0] pc_dir, pd_dir, port_a_function_select_high, port_b_function_select_low, port_b_function_select_high, port_c_function_select_low, port_c_function_select_high, port_d_function_select, input_source_select, rd_s;
	logic [3:0] sel, lcd;
	logic [31:0] dat, rdat, rdat_s;
	pfds_periph_tx_t tx;
	pfds_periph_rx_t alt, prx;
	pfds_drive_t pa_drv, pb_drv, pc_drv, pd_drv;
	int bad_count, n_tests;
	// Ordinary cases: address, write value, read-back value
	// Last column is the smaller variant, which has fewer implemented bits
	localparam logic [7:0] R_ADR [11] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18,
		8'h1C, 8'h24, 8'h20, 8'h3C};
	localparam logic [7:0] R_WR [11] = '{8'hFF, 8'hFF, 8'hA5, 8'h3C, 8'h5A, 8'hFF, 8'hFF,
		8'hFF, 8'hFF, 8'h5A, 8'hFF};
	localparam logic [7:0] R_RD [11] = '{8'hFF, 8'h3F, 8'hA5, 8'h3C, 8'h5A, 8'h3F, 8'hFF,
		8'h3F, 8'h3F, 8'h5A, 8'h00};
	localparam logic [7:0] R_RD_S [11] = '{8'hFF, 8'h03, 8'hA5, 8'h3C, 8'h5A, 8'h3F, 8'h3F,
		8'h00, 8'h30, 8'h00, 8'h00};
	pfds_top #(.LARGE_VARIANT(1'b1)) dut (.i_clk(i_clk), .i_reset_n(i_reset_n),
		.i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel),
		.i_wb_dat(dat), .o_wb_dat(rdat), .o_wb_ack(ack), .i_pa_pin(pa_pin),
		.i_pa_gpio_out(gpio), .i_periph_tx(tx), .i_alt_rx(alt), .o_pa_out(pa_out),
		.o_pa_oe(pa_oe), .o_pa_lcd_sel(lcd), .o_periph_rx(prx), .o_pa_drive(pa_drv),
		.o_pb_drive(pb_drv), .o_pc_drive(pc_drv), .o_pd_drive(pd_drv), .o_pb_dir(pb_dir),
		.o_pc_dir(pc_dir), .o_pd_dir(pd_dir), .o_port_a_function_select_high(port_a_function_select_high), .o_port_b_function_select_low(port_b_function_select_low), .o_port_b_function_select_high(port_b_function_select_high),
		.o_port_c_function_select_low(port_c_function_select_low), .o_port_c_function_select_high(port_c_function_select_high), .o_port_d_function_select(port_d_function_select), .o_ifs(input_source_select));
	// Smaller variant shares the bus; its answer comes on the same cycle
	pfds_top #(.LARGE_VARIANT(1'b0)) dut_small (.i_clk(i_clk), .i_reset_n(i_reset_n),
		.i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel),
		.i_wb_dat(dat), .o_wb_dat(rdat_s), .o_wb_ack(), .i_pa_pin(pa_pin),
		.i_pa_gpio_out(gpio), .i_periph_tx(tx), .i_alt_rx(alt), .o_pa_out(), .o_pa_oe(),
		.o_pa_lcd_sel(), .o_periph_rx(), .o_pa_drive(), .o_pb_drive(), .o_pc_drive(),
		.o_pd_drive(), .o_pb_dir(), .o_pc_dir(), .o_pd_dir(), .o_port_a_function_select_high(), .o_port_b_function_select_low(),
		.o_port_b_function_select_high(), .o_port_c_function_select_low(), .o_port_c_function_select_high(), .o_port_d_function_select(), .o_ifs());
	initial
	begin
		i_clk = 1'b0;
		forever #2.5 i_clk = ~i_clk;
	end
	task automatic print_verdict();
		$display("Checks %0d, mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : print_verdict
	task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask : check
	// One classic cycle; settles to the falling edge so outputs can be compared
	task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
		input logic [3:0] s);
		int n;
		@(posedge i_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= s;
		dat <= {24'h000000, d};
		n = 0;
		do
		begin
			@(posedge i_clk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		if (n >= 20)
		begin
			bad_count++;
			$display("[FAIL] bus answer expected ack seen none");
			print_verdict();
		end
		rd = rdat[7:0];
		rd_s = rdat_s[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		@(negedge i_clk);
	endtask : wb
	initial
	begin
		i_reset_n = 1'b0;
		{cyc, stb, we} = 3'h0;
		adr = 8'h00;
		sel = 4'hF;
		dat = 32'h00000000;
		pa_pin = 8'h00;
		gpio = 8'h00;
		tx = '0;
		alt = '0;
		repeat (6) @(posedge i_clk);
		i_reset_n <= 1'b1;
		@(negedge i_clk);
		check("pb_dir reset", pb_dir, 32'h7F);
		check("pa_oe reset", pa_oe, 32'h00);
		check("pc_dir reset", pc_dir, 32'h7F);
		check("pd_dir reset", pd_dir, 32'h0F);
		wb(1'b0, PFDS_OFF_DLS0, 8'h00, 4'hF);
		check("dls0 reset", rd, 32'h00);
		$display("Test reset done");
		for (int i = 0; i < 11; i++)
		begin
			wb(1'b1, R_ADR[i], R_WR[i], 4'hF);
			wb(1'b0, R_ADR[i], 8'h00, 4'hF);
			check("readback", rd, R_RD[i]);
			check("readback small", rd_s, R_RD_S[i]);
		end
		check("port_a_function_select_high out", port_a_function_select_high, 32'h3C);
		check("port_b_function_select_low out", port_b_function_select_low, 32'h5A);
		check("port_b_function_select_high out", port_b_function_select_high, 32'h3F);
		check("port_c_function_select_low out", port_c_function_select_low, 32'hFF);
		check("port_c_function_select_high out", port_c_function_select_high, 32'h3F);
		check("port_d_function_select out", port_d_function_select, 32'h5A);
		check("ifs out", input_source_select, 32'h3F);
		$display("Test register table done");
		wb(1'b1, PFDS_OFF_DLS0, 8'h00, 4'hE);
		wb(1'b0, PFDS_OFF_DLS0, 8'h00, 4'hF);
		check("masked write ignored", rd, 32'hFF);
		wb(1'b1, PFDS_OFF_PB_DIR, 8'h00, 4'hF);
		wb(1'b1, PFDS_OFF_PA_DIR, 8'h00, 4'hF);
		for (int c = 0; c < 4; c++)
		begin
			wb(1'b1, PFDS_OFF_DLS0, {c[1:0], ~c[1:0], 2'h0, c[1:0]}, 4'hF);
			check("pb6 level", pb_drv.level[6], c);
			check("pb4 level", pb_drv.level[4], c);
			check("pb3 level", pb_drv.level[3], {30'h0, ~c[1:0]});
			check("pa1 level", pa_drv.level[1], c);
			check("pa5 level", pa_drv.level[5], 32'h0);
		end
		wb(1'b1, PFDS_OFF_PB_DIR, 8'hFF, 4'hF);
		check("pb level input", pb_drv.level[6], 32'h0);
		check("pb enable input", pb_drv.en, 32'h00);
		wb(1'b1, PFDS_OFF_PC_DIR, 8'h00, 4'hF);
		wb(1'b1, PFDS_OFF_PD_DIR, 8'h00, 4'hF);
		wb(1'b1, PFDS_OFF_DLS1, 8'h39, 4'hF);
		check("pc0 level", pc_drv.level[0], 32'h1);
		check("pc5 level", pc_drv.level[5], 32'h2);
		check("pd3 level", pd_drv.level[3], 32'h3);
		check("pc enable", pc_drv.en, 32'h7F);
		check("pd enable", pd_drv.en, 32'h0F);
		$display("Test drive levels done");
		wb(1'b1, PFDS_OFF_PORT_A_FUNCTION_SELECT_LOW, 8'h8A, 4'hF);
		@(posedge i_clk);
		tx <= '{sdo: 1'b1, cmp_out: 1'b1, standard_timer_output: 1'b1, sda_low: 1'b0};
		@(negedge i_clk);
		check("pa peripheral out", pa_out[3:0], 32'hB);
		check("pa peripheral oe", pa_oe[3:0], 32'hF);
		check("pa no lcd", lcd, 32'h0);
		@(posedge i_clk);
		tx <= '0;
		wb(1'b1, PFDS_OFF_PORT_A_FUNCTION_SELECT_LOW, 8'hFF, 4'hF);
		check("pa lcd", lcd, 32'hF);
		wb(1'b1, PFDS_OFF_PORT_A_FUNCTION_SELECT_LOW, 8'h55, 4'hF);
		@(posedge i_clk);
		gpio <= 8'hA7;
		tx.sda_low <= 1'b1;
		@(negedge i_clk);
		check("pa alt1 out", pa_out[3:0], 32'h7);
		check("pa upper out", pa_out[7:4], 32'hA);
		check("pa upper oe", pa_oe[7:4], 32'hF);
		check("pa alt1 oe", pa_oe[3:0], 32'hF);
		check("sda not push-pull", pa_drv.en[3], 32'h0);
		$display("Test port A functions done");
		wb(1'b1, PFDS_OFF_PA_DIR, 8'hFF, 4'hF);
		wb(1'b1, PFDS_OFF_PORT_A_FUNCTION_SELECT_LOW, 8'h00, 4'hF);
		wb(1'b1, PFDS_OFF_IFS, 8'h00, 4'hF);
		@(posedge i_clk);
		pa_pin <= 8'h0E;
		alt <= '0;
		repeat (3) @(posedge i_clk);
		@(negedge i_clk);
		check("irq1 from pin", prx.irq1, 32'h1);
		check("irq0 from pin", prx.irq0, 32'h1);
		check("serial in gpio", prx.serial_in, 32'h0);
		wb(1'b1, PFDS_OFF_PORT_A_FUNCTION_SELECT_LOW, 8'h40, 4'hF);
		check("serial in pin", prx.serial_in, 32'h1);
		wb(1'b1, PFDS_OFF_IFS, 8'h30, 4'hF);
		check("irq1 from alt", prx.irq1, 32'h0);
		check("irq0 from alt", prx.irq0, 32'h0);
		$display("Test input source done");
		@(posedge i_clk);
		i_reset_n <= 1'b0;
		repeat (2) @(posedge i_clk);
		i_reset_n <= 1'b1;
		@(negedge i_clk);
		check("pd_dir mid reset", pd_dir, 32'h0F);
		check("pc enable mid reset", pc_drv.en, 32'h00);
		check("ifs mid reset", input_source_select, 32'h00);
		wb(1'b0, PFDS_OFF_PORT_A_FUNCTION_SELECT_LOW, 8'h00, 4'hF);
		check("port_a_function_select_low mid reset", rd, 32'h00);
		$display("Test reset in mid-run done");
		print_verdict();
	end
endmodule : tb_pin_function_and_drive_select
